//--- logic/mode_seq_consts.vh
// Constants for the battery monitor mode sequencer.
// Assumes a 250 MHz system clock; times are converted to cycle counts here.
`ifndef MODE_SEQ_CONSTS_VH
`define MODE_SEQ_CONSTS_VH
`define CLK_FREQ_HZ 250000000
`define PAIR_WINDOW_S 4
`define PAIR_WINDOW_CYC (`PAIR_WINDOW_S * `CLK_FREQ_HZ)
`define SHDN_DELAY_S 10
`define SHDN_DELAY_CYC (`SHDN_DELAY_S * `CLK_FREQ_HZ)
`define OSC_HOLD_MS 25
`define OSC_HOLD_CYC (`OSC_HOLD_MS * (`CLK_FREQ_HZ / 1000))
`define WAKE_BUDGET_MS 10
`define WAKE_BUDGET_CYC (`WAKE_BUDGET_MS * (`CLK_FREQ_HZ / 1000))
`define CMD_NONE 16'h0000
`define CMD_HOLD_EXIT 16'h000E
`define CMD_HOLD 16'h000F
`define CMD_SHUTDOWN 16'h0010
`define CMD_RESET 16'h0012
`define CMD_EDIT_ENTER 16'h0090
`define CMD_EDIT_EXIT 16'h0092
`define CMD_SWITCH_ALLOW 16'h0022
`define REG_ADDR_CTRL 8'h00
`define REG_ADDR_STATUS 8'h04
`define REG_ADDR_CMD 8'h08
`define REG_ADDR_OVR 8'h0C
`define CTRL_RESET 8'h00
`define CTRL_OSC_KEEP_BIT 0
`define CTRL_HW_OVERTEMP_SHUTDOWN_EN_EN_BIT 1
`define CTRL_TEMP_SD_EN_BIT 2
`define OVR_DSG_BIT 0
`define OVR_CHG_BIT 1
`define MODE_NORMAL 3'h0
`define MODE_STARTUP 3'h1
`define MODE_HOLD 3'h2
`define MODE_SD_WAIT 3'h3
`define MODE_SOFT_SD 3'h4
`define MODE_SHUTDOWN 3'h5
`define MODE_EDIT 3'h6
`define MODE_WAKE 3'h7
`endif

//--- logic/battery_monitor_mode_sequencer.v
// Operating mode sequencer: hold mode, staged shutdown and settings-edit mode.
// Assumes external pins are asynchronous; the register port is on sys_clk.
`timescale 1ns/10ps
`default_nettype none
`include "mode_seq_consts.vh"

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Hold entry needs two hold commands within 4s.
// - Hold exits on exit command or pin rise.
// - Regulator reset or die overtemp in hold: shutdown.
// - Leaving hold runs startup measurement first.
// - Hold keeps switches off, only checks active.
// - Oscillator may stop; serial traffic stretches clock.
// - Woken oscillator stays on about 25 ms.
// - Exit command or pin rise leaves hold mode for startup.
// - Two shutdown commands within 4s start shutdown.
// - Low stack or real-cell voltage starts shutdown.
// - Optional internal overtemperature starts shutdown.
// - Ten second delay; third command skips it.
// - Shutdown start: normal mode, no sleep, clear enable if from hold or sleep.
// - From hold, set both switch block bits.
// - Delay ignores recovery; exit or reset aborts.
// - Wake from shutdown completes within 10 ms.
// - Die overtemp detector starts shutdown when enabled.
// - Wake condition present holds soft shutdown.
// - Exit command in soft shutdown restarts fully.
// - Edit stops measuring, clears faults; exit restarts.
module battery_monitor_mode_sequencer #(
  parameter [31:0] PAIR_WINDOW_CYC = `PAIR_WINDOW_CYC,
  parameter [31:0] SHDN_DELAY_CYC = `SHDN_DELAY_CYC,
  parameter [31:0] OSC_HOLD_CYC = `OSC_HOLD_CYC,
  parameter [31:0] WAKE_BUDGET_CYC = `WAKE_BUDGET_CYC
) (
  input wire sys_clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire thermistor_pin,
  input wire bottom_cell_pin,
  input wire core_por,
  input wire die_overtemp,
  input wire stack_low,
  input wire cell_low_mask_any,
  input wire int_temp_high,
  input wire aux_regulator_fault,
  input wire osc_integrity_fault,
  input wire serial_activity,
  input wire osc_running,
  input wire startup_done,
  input wire sleep_mode_in,
  output reg low_freq_oscillator_en,
  output reg scl_stretch,
  output reg switches_allowed,
  output reg measure_en,
  output reg protect_en,
  output reg clear_faults,
  output reg startup_req,
  output reg sleep_block,
  output reg power_off,
  output reg core_restart,
  output reg settings_edit_flag,
  output reg autonomous_switch_enable,
  output reg discharge_switch_block,
  output reg charge_switch_block,
  output reg check_fault_flag
);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  reg [7:0] sync1_q;
  reg [7:0] sync2_q;
  reg ts_prev_q;
  reg vc_prev_q;
  wire ts_s = sync2_q[0];
  wire vc_s = sync2_q[1];
  wire por_s = sync2_q[2];
  wire dot_s = sync2_q[3];
  wire act_s = sync2_q[4];
  wire run_s = sync2_q[5];
  wire aux_s = sync2_q[6];
  wire lfo_s = sync2_q[7];
  // Edge registers reset low, which is the idle level of both wake pins.
  wire pin_rise = (ts_s & ~ts_prev_q) | (vc_s & ~vc_prev_q);
  wire wake_present = ts_s | vc_s;

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      ts_prev_q <= 1'b0;
      vc_prev_q <= 1'b0;
    end else begin
      sync1_q <= {osc_integrity_fault, aux_regulator_fault, osc_running, serial_activity,
                  die_overtemp, core_por, bottom_cell_pin, thermistor_pin};
      sync2_q <= sync1_q;
      ts_prev_q <= ts_s;
      vc_prev_q <= vc_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register port and command decode.
  // Read data stand for one cycle after the read strobe and read as zero otherwise.
  reg [7:0] ctrl_q;
  reg [15:0] cmd_q;
  reg cmd_vld_q;
  wire wr_cmd = reg_wr && (reg_addr == `REG_ADDR_CMD);
  wire wr_ovr = reg_wr && (reg_addr == `REG_ADDR_OVR);
  reg [2:0] mode_q;
  reg [2:0] mode_d;

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_q <= `CTRL_RESET;
      cmd_q <= `CMD_NONE;
      cmd_vld_q <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      cmd_vld_q <= wr_cmd;
      if (wr_cmd)
        cmd_q <= reg_wdata;
      if (reg_wr && (reg_addr == `REG_ADDR_CTRL))
        ctrl_q <= reg_wdata[7:0];
      if (reg_rd) begin
        case (reg_addr)
          `REG_ADDR_CTRL: reg_rdata <= {8'h00, ctrl_q};
          `REG_ADDR_STATUS: reg_rdata <= {8'h00, check_fault_flag, settings_edit_flag,
                                          autonomous_switch_enable, low_freq_oscillator_en,
                                          1'b0, mode_q};
          `REG_ADDR_CMD: reg_rdata <= cmd_q;
          `REG_ADDR_OVR: reg_rdata <= {14'h0000, charge_switch_block, discharge_switch_block};
          default: reg_rdata <= 16'h0000;
        endcase
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  wire c_hold = cmd_vld_q && (cmd_q == `CMD_HOLD);
  wire c_exit = cmd_vld_q && (cmd_q == `CMD_HOLD_EXIT);
  wire c_sd = cmd_vld_q && (cmd_q == `CMD_SHUTDOWN);
  wire c_rst = cmd_vld_q && (cmd_q == `CMD_RESET);
  wire c_ed_in = cmd_vld_q && (cmd_q == `CMD_EDIT_ENTER);
  wire c_ed_out = cmd_vld_q && (cmd_q == `CMD_EDIT_EXIT);
  wire c_allow = cmd_vld_q && (cmd_q == `CMD_SWITCH_ALLOW);

  //////////////////////////////////////////////////////////////////////////
  // Pair detection for double-send commands.
  reg hold_arm_q;
  reg sd_arm_q;
  reg [31:0] pair_cnt_q;
  wire pair_open = pair_cnt_q != 32'h0000_0000;
  wire hold_pair = c_hold && hold_arm_q && pair_open;
  wire sd_pair = c_sd && sd_arm_q && pair_open;
  // Any other command between the two copies disarms both pairs.

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      hold_arm_q <= 1'b0;
      sd_arm_q <= 1'b0;
      pair_cnt_q <= 32'h0000_0000;
    end else if (c_hold || c_sd) begin
      hold_arm_q <= c_hold && !hold_pair;
      sd_arm_q <= c_sd && !sd_pair;
      pair_cnt_q <= (hold_pair || sd_pair) ? 32'h0000_0000 : PAIR_WINDOW_CYC;
    end else if (cmd_vld_q) begin
      hold_arm_q <= 1'b0;
      sd_arm_q <= 1'b0;
    end else if (pair_open) begin
      pair_cnt_q <= pair_cnt_q - 32'h0000_0001;
    end else begin
      hold_arm_q <= 1'b0;
      sd_arm_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode state machine.
  reg [31:0] tmr_q;
  reg [31:0] osc_cnt_q;
  wire tmr_zero = tmr_q == 32'h0000_0000;
  wire run_mode = (mode_q == `MODE_NORMAL);
  wire meas_trip = stack_low | cell_low_mask_any;
  wire temp_trip = int_temp_high & ctrl_q[`CTRL_TEMP_SD_EN_BIT];
  wire ot_trip = dot_s & ctrl_q[`CTRL_HW_OVERTEMP_SHUTDOWN_EN_EN_BIT];
  wire sd_start = sd_pair || (run_mode && (meas_trip || temp_trip)) || ot_trip;
  wire check_trip = aux_s | lfo_s;

  always @* begin
    mode_d = mode_q;
    case (mode_q)
      `MODE_WAKE: begin
        if (tmr_zero || startup_done)
          mode_d = `MODE_STARTUP;
      end
      `MODE_STARTUP: begin
        if (startup_done)
          mode_d = `MODE_NORMAL;
      end
      `MODE_NORMAL: begin
        if (sd_start)
          mode_d = `MODE_SD_WAIT;
        else if (hold_pair)
          mode_d = `MODE_HOLD;
        else if (c_ed_in)
          mode_d = `MODE_EDIT;
      end
      // A regulator reset or die overtemperature outranks every command.
      `MODE_HOLD: begin
        if (por_s || dot_s || check_trip)
          mode_d = `MODE_SHUTDOWN;
        else if (sd_pair)
          mode_d = `MODE_SD_WAIT;
        else if (c_exit || pin_rise)
          mode_d = `MODE_STARTUP;
      end
      `MODE_SD_WAIT: begin
        if (c_exit || c_rst)
          mode_d = `MODE_WAKE;
        else if (tmr_zero || c_sd)
          mode_d = `MODE_SOFT_SD;
      end
      `MODE_SOFT_SD: begin
        if (c_exit)
          mode_d = `MODE_WAKE;
        else if (!wake_present)
          mode_d = `MODE_SHUTDOWN;
      end
      `MODE_EDIT: begin
        if (c_ed_out)
          mode_d = `MODE_STARTUP;
      end
      `MODE_SHUTDOWN: begin
        if (wake_present)
          mode_d = `MODE_WAKE;
      end
      default: mode_d = `MODE_WAKE;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!reset_n)
      mode_q <= `MODE_WAKE;
    else
      mode_q <= mode_d;
  end

  // The shared timer counts the shutdown delay or the wake budget.
  always @(posedge sys_clk) begin
    if (!reset_n)
      tmr_q <= 32'h0000_0000;
    else if (mode_d == `MODE_SD_WAIT && mode_q != `MODE_SD_WAIT)
      tmr_q <= SHDN_DELAY_CYC;
    else if (mode_d == `MODE_WAKE && mode_q != `MODE_WAKE)
      tmr_q <= WAKE_BUDGET_CYC;
    else if (!tmr_zero)
      tmr_q <= tmr_q - 32'h0000_0001;
  end

  // Serial traffic in hold keeps the oscillator up for a while.
  always @(posedge sys_clk) begin
    if (!reset_n)
      osc_cnt_q <= 32'h0000_0000;
    else if (mode_q == `MODE_HOLD && act_s)
      osc_cnt_q <= OSC_HOLD_CYC;
    else if (osc_cnt_q != 32'h0000_0000)
      osc_cnt_q <= osc_cnt_q - 32'h0000_0001;
  end

  //////////////////////////////////////////////////////////////////////////
  // Output decode.
  wire in_hold = mode_q == `MODE_HOLD;
  wire osc_need = !in_hold || ctrl_q[`CTRL_OSC_KEEP_BIT] || act_s || osc_cnt_q != 32'h0;
  wire sd_enter = mode_d == `MODE_SD_WAIT && mode_q != `MODE_SD_WAIT;
  // Measuring follows the next mode, so it stops on the edge at which the edit flag rises.
  wire live = mode_d == `MODE_NORMAL || mode_d == `MODE_SD_WAIT;
  wire edit_enter = mode_d == `MODE_EDIT && mode_q != `MODE_EDIT;
  wire startup_enter = mode_d == `MODE_STARTUP && mode_q != `MODE_STARTUP;
  wire wake_enter = mode_d == `MODE_WAKE && mode_q != `MODE_WAKE;
  wire sd_pending = mode_d == `MODE_SD_WAIT || mode_d == `MODE_SOFT_SD;
  wire block_set = sd_enter && in_hold;
  wire enable_clear = sd_enter && (in_hold || sleep_mode_in);

  //////////////////////////////////////////////////////////////////////////
  // Oscillator request and clock stretch.
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      low_freq_oscillator_en <= 1'b1;
      scl_stretch <= 1'b0;
    end else begin
      low_freq_oscillator_en <= osc_need;
      scl_stretch <= in_hold && act_s && !run_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode enables; switches drop on the edge that leaves normal mode and rise one cycle after entering it.
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      switches_allowed <= 1'b0;
      measure_en <= 1'b0;
      protect_en <= 1'b0;
      sleep_block <= 1'b0;
      power_off <= 1'b0;
      settings_edit_flag <= 1'b0;
    end else begin
      switches_allowed <= run_mode && (mode_q == mode_d);
      measure_en <= live;
      protect_en <= live;
      sleep_block <= sd_pending;
      power_off <= mode_d == `MODE_SHUTDOWN;
      settings_edit_flag <= mode_d == `MODE_EDIT;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // One-cycle pulses on mode entry.
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      clear_faults <= 1'b0;
      startup_req <= 1'b0;
      core_restart <= 1'b0;
    end else begin
      clear_faults <= edit_enter;
      startup_req <= startup_enter;
      core_restart <= wake_enter;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status bits; a hardware set wins over a clear in the same cycle.
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      check_fault_flag <= 1'b0;
      autonomous_switch_enable <= 1'b1;
      discharge_switch_block <= 1'b0;
      charge_switch_block <= 1'b0;
    end else begin
      if (in_hold && check_trip)
        check_fault_flag <= 1'b1;
      else if (core_restart)
        check_fault_flag <= 1'b0;
      if (c_allow)
        autonomous_switch_enable <= 1'b1;
      else if (enable_clear)
        autonomous_switch_enable <= 1'b0;
      else if (core_restart)
        autonomous_switch_enable <= 1'b1;
      if (block_set) begin
        discharge_switch_block <= 1'b1;
        charge_switch_block <= 1'b1;
      end else if (wr_ovr) begin
        discharge_switch_block <= reg_wdata[`OVR_DSG_BIT];
        charge_switch_block <= reg_wdata[`OVR_CHG_BIT];
      end else if (core_restart) begin
        discharge_switch_block <= 1'b0;
        charge_switch_block <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

//--- tb/host_model.sv
// Host processor model issuing register accesses and subcommands.
// Assumes one caller at a time; strobes last one cycle.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic sys_clk,
  input wire logic [15:0] reg_rdata,
  output logic [7:0] reg_addr = 8'h00,
  output logic [15:0] reg_wdata = 16'h0000,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0
);
  // Released write data is inverted so a stale value is never mistaken for valid.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- tb/mode_seq_checker.sv
// Assertions on the mode sequencer ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module mode_seq_checker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic osc_running,
  input wire logic low_freq_oscillator_en,
  input wire logic scl_stretch,
  input wire logic switches_allowed,
  input wire logic measure_en,
  input wire logic protect_en,
  input wire logic sleep_block,
  input wire logic power_off,
  input wire logic settings_edit_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_edit_cmd;
    reg_wr && reg_addr == 8'h08 && reg_wdata == 16'h0090;
  endsequence
  sequence s_osc_up;
    osc_running [*6];
  endsequence
  AST_EDIT_ON: assert property (s_edit_cmd ##0 measure_en |-> ##[1:4] settings_edit_flag)
    else $error("edit flag missing after edit entry");
  AST_EDIT_STOP: assert property (settings_edit_flag |-> !measure_en && !protect_en)
    else $error("measuring during edit");
  AST_OFF_QUIET: assert property (power_off |-> !switches_allowed && !measure_en)
    else $error("active while off");
  AST_SD_DELAY: assert property ($rose(sleep_block) |-> !power_off [*2])
    else $error("shutdown without delay");
  AST_RD_UNMAP: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  AST_STRETCH_END: assert property (s_osc_up |-> !scl_stretch)
    else $error("stretch with oscillator running");
  AST_STRETCH_REQ: assert property ($rose(scl_stretch) |-> ##[0:1] low_freq_oscillator_en)
    else $error("stretch without oscillator request");
endmodule
bind battery_monitor_mode_sequencer mode_seq_checker i_chk (.sys_clk(sys_clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_running(osc_running),
  .low_freq_oscillator_en(low_freq_oscillator_en), .scl_stretch(scl_stretch),
  .switches_allowed(switches_allowed), .measure_en(measure_en), .protect_en(protect_en),
  .sleep_block(sleep_block), .power_off(power_off), .settings_edit_flag(settings_edit_flag));
`default_nettype wire

//--- tb/battery_monitor_mode_sequencer_tb_top.sv
// Testbench for the mode sequencer: host command sequences and pin events.
// Assumes the host model and shortened parameter counts.
`timescale 1ns/10ps
`default_nettype none
module battery_monitor_mode_sequencer_tb_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic tp = 1'b0, bc = 1'b0, ot = 1'b0, sl = 1'b0, cl = 1'b0;
  logic sa = 1'b0, osc = 1'b0, sd = 1'b1;
  logic cp = 1'b0, it = 1'b0, af = 1'b0;
  logic [7:0] a;
  logic [15:0] wd, rdat, v;
  logic wr, rd, osc_en, sw, me, sb, po, ef;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2 sys_clk = ~sys_clk;
  // The oscillator starts one cycle after it is requested.
  always @(posedge sys_clk) osc <= osc_en;
  host_model i_host (.sys_clk(sys_clk), .reg_rdata(rdat), .reg_addr(a), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd));
  battery_monitor_mode_sequencer #(.PAIR_WINDOW_CYC(50), .SHDN_DELAY_CYC(100),
    .OSC_HOLD_CYC(40), .WAKE_BUDGET_CYC(60)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
    .thermistor_pin(tp), .bottom_cell_pin(bc), .core_por(cp), .die_overtemp(ot),
    .stack_low(sl), .cell_low_mask_any(cl), .int_temp_high(it),
    .aux_regulator_fault(af), .osc_integrity_fault(1'b0), .serial_activity(sa),
    .osc_running(osc), .startup_done(sd), .sleep_mode_in(1'b0),
    .low_freq_oscillator_en(osc_en), .scl_stretch(), .switches_allowed(sw),
    .measure_en(me), .protect_en(), .clear_faults(), .startup_req(), .sleep_block(sb),
    .power_off(po), .core_restart(), .settings_edit_flag(ef),
    .autonomous_switch_enable(), .discharge_switch_block(), .charge_switch_block(),
    .check_fault_flag());
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic md(input logic [2:0] e);
    i_host.rd(8'h04, v);
    chk("mode", v & 16'h0007, {13'h0000, e});
  endtask
  task automatic cmd(input logic [15:0] c);
    i_host.wr(8'h08, c);
  endtask
  task automatic pair(input logic [15:0] c);
    cmd(c);
    cmd(c);
    w(6);
  endtask
  task automatic rst;
    reset_n <= 1'b0;
    w(4);
    reset_n <= 1'b1;
    w(80);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    rst();
    md(3'h0);
    i_host.wr(8'h00, 16'h0006);
    i_host.rd(8'h00, v);
    chk("ctrl", v, 16'h0006);
    i_host.rd(8'h10, v);
    chk("unmapped", v, 16'h0000);
    cmd(16'h000F);
    w(60);
    cmd(16'h000F);
    w(6);
    md(3'h0);
    w(60);
    pair(16'h000F);
    md(3'h2);
    chk("sw", {15'h0000, sw}, 16'h0000);
    cmd(16'h0012);
    w(6);
    md(3'h2);
    sa <= 1'b1;
    w(3);
    sa <= 1'b0;
    w(10);
    chk("osc", {15'h0000, osc_en}, 16'h0001);
    w(60);
    chk("osc", {15'h0000, osc_en}, 16'h0000);
    i_host.wr(8'h0C, 16'h0003);
    sd <= 1'b0;
    cmd(16'h000E);
    w(6);
    md(3'h1);
    sd <= 1'b1;
    w(10);
    md(3'h0);
    pair(16'h000F);
    bc <= 1'b1;
    w(20);
    md(3'h0);
    bc <= 1'b0;
    pair(16'h000F);
    i_host.wr(8'h0C, 16'h0000);
    i_host.rd(8'h0C, v);
    chk("ovr", v & 16'h0003, 16'h0000);
    pair(16'h0010);
    md(3'h3);
    chk("sleep_block", {15'h0000, sb}, 16'h0001);
    i_host.rd(8'h0C, v);
    chk("ovr", v & 16'h0003, 16'h0003);
    cmd(16'h0010);
    w(8);
    md(3'h5);
    rst();
    pair(16'h000F);
    ot <= 1'b1;
    w(150);
    md(3'h5);
    ot <= 1'b0;
    rst();
    sl <= 1'b1;
    w(6);
    md(3'h3);
    sl <= 1'b0;
    w(20);
    md(3'h3);
    cmd(16'h0012);
    w(80);
    md(3'h0);
    cl <= 1'b1;
    w(6);
    md(3'h3);
    cl <= 1'b0;
    cmd(16'h000E);
    w(80);
    md(3'h0);
    tp <= 1'b1;
    pair(16'h0010);
    w(60);
    md(3'h3);
    w(60);
    md(3'h4);
    chk("sw", {15'h0000, sw}, 16'h0000);
    tp <= 1'b0;
    w(8);
    md(3'h5);
    rst();
    tp <= 1'b1;
    pair(16'h0010);
    cmd(16'h0010);
    w(8);
    md(3'h4);
    cmd(16'h000E);
    w(80);
    md(3'h0);
    tp <= 1'b0;
    i_host.wr(8'h0C, 16'h0003);
    cmd(16'h0090);
    w(6);
    chk("edit", {15'h0000, ef}, 16'h0001);
    chk("measure", {15'h0000, me}, 16'h0000);
    cmd(16'h0092);
    w(80);
    md(3'h0);
    pair(16'h000F);
    af <= 1'b1;
    w(8);
    md(3'h5);
    i_host.rd(8'h04, v);
    chk("check_fault", v & 16'h0080, 16'h0080);
    af <= 1'b0;
    rst();
    pair(16'h000F);
    cp <= 1'b1;
    w(8);
    md(3'h5);
    cp <= 1'b0;
    rst();
    i_host.wr(8'h00, 16'h0004);
    it <= 1'b1;
    w(6);
    md(3'h3);
    it <= 1'b0;
    give_verdict();
  end
endmodule
`default_nettype wire
